// [inc/cmp_ctrl_pkg.sv]
/*
 package for the comparator bank control block: register map, fields,
 reset values, bus and control field carriers.
 assumes a 16-bit register port and a single 20 MHz instruction clock.
*/
// Contract
// RQ1: input select code routes one of four pins
// RQ2: polarity bit one inverts comparator result
// RQ3: state bit shows output after polarity
// RQ4: filter suppresses pulses shorter than two cycles
// RQ5: sleep or idle bypasses filter, async wake
// RQ6: any stop-in-idle bit halts whole group
// RQ7: filtered event gives one-cycle pulse
// RQ8: enable zero turns off dac and comparator
// RQ9: external select bit picks external reference
// RQ10: range bit picks half supply or internal
// RQ11: ten-bit code sets threshold, zero gives zero
// RQ12: dac output enable drives shared pin
// RQ13: software sets at most one dac output enable
// RQ14: reserved and unimplemented bits read zero
// RQ15: selected pad digital input buffer turned off
// RQ16: comparator output feeds several consumers at once
// RQ17: writable bits reset to zero
package cmp_ctrl_pkg;
   localparam int NUM_CMP = 4;
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 16;
   localparam int FILT_CYCLES = 2;

   // register index: comparator n control at 2n, code at 2n+1
   localparam logic [ADDR_W-1:0] CTRL_BASE   = 4'h0;
   localparam logic [ADDR_W-1:0] INT_STATUS  = 4'h8;
   localparam logic [ADDR_W-1:0] INT_MASK    = 4'h9;

   localparam int EN_BIT    = 15;
   localparam int SIDL_BIT  = 13;
   localparam int DAC_OUTPUT_ENABLE_BIT = 8;
   localparam int SEL_LSB   = 6;
   localparam int EXT_BIT   = 5;
   localparam int STATE_BIT = 3;
   localparam int POL_BIT   = 1;
   localparam int RANGE_BIT = 0;
   localparam logic [15:0] CTRL_WMASK = 16'hA1E3;
   localparam logic [15:0] CODE_WMASK = 16'h03FF;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [9:0]  CODE_RESET = 10'h000;

   typedef enum logic [1:0] {
      REF_INTERNAL_REFERENCE_VOLTAGE = 2'b00,
      REF_HALF   = 2'b01,
      REF_EXT    = 2'b10,
      REF_OFF    = 2'b11
   } ref_src_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

   typedef struct packed {
      logic       enable;
      logic       stop_idle;
      logic       dac_oe;
      logic [1:0] sel;
      logic       ext_ref;
      logic       polarity;
      logic       range;
   } ctrl_fields_t;
endpackage

// [rtl/cmp_bank_ctrl.sv]
/*
 control block for a bank of four comparators with reference dacs.
 assumes raw comparator outputs arrive asynchronously; idle and sleep
 levels come from the clock controller on core_clk_i.
*/
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cmp_bank_ctrl (
   input  wire logic                            core_clk_i,
   input  wire logic                            rst_i,
   input  wire cmp_ctrl_pkg::bus_req_t          bus_i,
   output logic [15:0]                          rdata_o,
   input  wire logic [cmp_ctrl_pkg::NUM_CMP-1:0] cmp_raw_i,
   input  wire logic                            idle_i,
   input  wire logic                            sleep_i,
   output logic [cmp_ctrl_pkg::NUM_CMP*2-1:0]   in_sel_o,
   output logic [cmp_ctrl_pkg::NUM_CMP*4-1:0]   pad_ibuf_off_o,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]     cmp_power_o,
   output logic [cmp_ctrl_pkg::NUM_CMP*2-1:0]   ref_src_o,
   output logic [cmp_ctrl_pkg::NUM_CMP*10-1:0]  dac_code_o,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]     dac_pin_en_o,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]     cmp_out_o,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]     adc_trig_o,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]     irq_pulse_o,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]     wake_o,
   output logic                                 irq_o
);
   import cmp_ctrl_pkg::*;

   typedef struct packed {
      logic [15:0]        rdata;
      logic [NUM_CMP-1:0] status;
      logic [NUM_CMP-1:0] mask;
      logic               irq;
      logic [NUM_CMP*2-1:0]  in_sel;
      logic [NUM_CMP*4-1:0]  ibuf_off;
      logic [NUM_CMP-1:0]    power;
      logic [NUM_CMP*2-1:0]  ref_src;
      logic [NUM_CMP*10-1:0] code;
      logic [NUM_CMP-1:0]    dac_pin;
      logic [NUM_CMP-1:0]    out;
      logic [NUM_CMP-1:0]    trig;
      logic                  idle_s1;
      logic                  idle_s2;
      logic                  sleep_s1;
      logic                  sleep_s2;
   } top_state_t;

   top_state_t q, d;

   ctrl_fields_t       fields [NUM_CMP];
   logic [9:0]         codes  [NUM_CMP];
   logic [NUM_CMP-1:0] ctrl_we;
   logic [NUM_CMP-1:0] code_we;
   logic [NUM_CMP-1:0] run;
   logic [NUM_CMP-1:0] filt;
   logic [NUM_CMP-1:0] pulse;
   logic [NUM_CMP-1:0] wake_raw;
   logic [NUM_CMP-1:0] sidl_vec;
   logic               group_stop;
   logic               low_power;

   // RQ6: any stop bit halts group
   assign group_stop = q.idle_s2 & (|sidl_vec);
   assign low_power = q.idle_s2 | q.sleep_s2;

   genvar g;
   generate
      for (g = 0; g < NUM_CMP; g++) begin : g_cmp
         assign ctrl_we[g] = bus_i.wr && bus_i.addr == ADDR_W'(CTRL_BASE + 2 * g);
         assign code_we[g] = bus_i.wr && bus_i.addr == ADDR_W'(CTRL_BASE + 2 * g + 1);
         assign sidl_vec[g] = fields[g].stop_idle;
         // RQ8: disabled or halted comparator stops
         assign run[g] = fields[g].enable & ~group_stop;

         cmp_reg_slot u_slot (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .ctrl_we_i  (ctrl_we[g]),
            .code_we_i  (code_we[g]),
            .wdata_i    (bus_i.wdata),
            .fields_o   (fields[g]),
            .code_o     (codes[g])
         );

         // RQ2: polarity applied before filtering
         cmp_glitch_filter u_filt (
            .core_clk_i  (core_clk_i),
            .rst_i       (rst_i),
            .raw_i       (cmp_raw_i[g] ^ fields[g].polarity),
            .run_i       (run[g]),
            .low_power_i (low_power),
            .filt_o      (filt[g]),
            .pulse_o     (pulse[g]),
            .wake_o      (wake_raw[g])
         );
      end
   endgenerate

   always_comb begin
      d = q;
      d.rdata = 16'h0000;
      // low power levels synchronised
      d.idle_s1 = idle_i;
      d.idle_s2 = q.idle_s1;
      d.sleep_s1 = sleep_i;
      d.sleep_s2 = q.sleep_s1;
      for (int i = 0; i < NUM_CMP; i++) begin
         // RQ1: input select code
         d.in_sel[2*i+:2] = fields[i].sel;
         // RQ15: selected pad buffer off
         d.ibuf_off[4*i+:4] = fields[i].enable ? (4'h1 << fields[i].sel) : 4'h0;
         d.power[i] = run[i];
         // RQ9: external reference wins, RQ10: range
         if (!run[i]) begin
            d.ref_src[2*i+:2] = REF_OFF;
         end else if (fields[i].ext_ref) begin
            d.ref_src[2*i+:2] = REF_EXT;
         end else if (fields[i].range) begin
            d.ref_src[2*i+:2] = REF_HALF;
         end else begin
            d.ref_src[2*i+:2] = REF_INTERNAL_REFERENCE_VOLTAGE;
         end
         // RQ11: code drives dac threshold
         d.code[10*i+:10] = run[i] ? codes[i] : 10'h000;
         // RQ12: shared pin driver enable
         d.dac_pin[i] = run[i] & fields[i].dac_oe;
         // RQ16: one output, many consumers
         d.out[i] = filt[i];
         d.trig[i] = pulse[i];
      end
      // sticky status: set wins over clear
      d.status = (q.status & ~((bus_i.wr && bus_i.addr == INT_STATUS) ?
                  bus_i.wdata[NUM_CMP-1:0] : '0)) | pulse;
      if (bus_i.wr && bus_i.addr == INT_MASK) begin
         d.mask = bus_i.wdata[NUM_CMP-1:0];
      end
      d.irq = |(d.status & d.mask);
      if (bus_i.rd) begin
         if (bus_i.addr < ADDR_W'(2 * NUM_CMP)) begin
            if (!bus_i.addr[0]) begin
               // RQ3: state after polarity, RQ14: zeros
               d.rdata = {fields[bus_i.addr[2:1]].enable, 1'b0,
                          fields[bus_i.addr[2:1]].stop_idle, 4'h0,
                          fields[bus_i.addr[2:1]].dac_oe,
                          fields[bus_i.addr[2:1]].sel,
                          fields[bus_i.addr[2:1]].ext_ref, 1'b0,
                          filt[bus_i.addr[2:1]], 1'b0,
                          fields[bus_i.addr[2:1]].polarity,
                          fields[bus_i.addr[2:1]].range};
            end else begin
               d.rdata = {6'h00, codes[bus_i.addr[2:1]]};
            end
         end else if (bus_i.addr == INT_STATUS) begin
            d.rdata = {12'h000, q.status};
         end else if (bus_i.addr == INT_MASK) begin
            d.rdata = {12'h000, q.mask};
         end else begin
            d.rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.ref_src <= {NUM_CMP{REF_OFF}};
      end else begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
   assign in_sel_o = q.in_sel;
   assign pad_ibuf_off_o = q.ibuf_off;
   assign cmp_power_o = q.power;
   assign ref_src_o = q.ref_src;
   assign dac_code_o = q.code;
   assign dac_pin_en_o = q.dac_pin;
   assign cmp_out_o = q.out;
   assign adc_trig_o = q.trig;
   assign irq_pulse_o = q.trig;
   // RQ5: asynchronous wake path
   assign wake_o = wake_raw;
   assign irq_o = q.irq;

   // RQ7: adc trigger single cycle
   chk_trig_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      adc_trig_o[0] |=> !adc_trig_o[0]) else $error("trigger wider than one cycle"); // RQ7
   // RQ8: disabled comparator unpowered
   chk_disable_power: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !fields[0].enable |=> !cmp_power_o[0] && !dac_pin_en_o[0])
      else $error("disabled comparator powered"); // RQ8
   // RQ6: group stop in idle
   chk_group_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.idle_s2 && (|sidl_vec)) |=> cmp_power_o == '0) else $error("group not halted"); // RQ6
   // RQ9: external reference priority
   chk_ext_ref: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (run[0] && fields[0].ext_ref) |=> ref_src_o[1:0] == REF_EXT)
      else $error("external reference not chosen"); // RQ9
   // RQ10: range selection
   chk_range_sel: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (run[0] && !fields[0].ext_ref && fields[0].range) |=> ref_src_o[1:0] == REF_HALF)
      else $error("range not applied"); // RQ10
   // RQ3: state readback
   chk_state_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (bus_i.rd && bus_i.addr == CTRL_BASE) |=> rdata_o[STATE_BIT] == $past(filt[0]))
      else $error("state bit wrong"); // RQ3
   // RQ14: code register upper zero
   chk_code_upper: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (bus_i.rd && bus_i.addr == 4'h1) |=> rdata_o[15:10] == 6'h00)
      else $error("code upper bits nonzero"); // RQ14
   // RQ1: select forwarded
   chk_sel_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> in_sel_o[1:0] == $past(fields[0].sel)) else $error("select not routed"); // RQ1
   // RQ12: shared pin follows enable
   chk_pin_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (run[2] && fields[2].dac_oe) |=> dac_pin_en_o[2])
      else $error("dac pin not driven"); // RQ12
   // RQ15: one pad buffer off
   chk_ibuf_onehot: assert property (@(posedge core_clk_i) disable iff (rst_i)
      fields[0].enable |=> $onehot(pad_ibuf_off_o[3:0]))
      else $error("pad buffer select wrong"); // RQ15
   // RQ11: stopped dac code zero
   chk_code_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run[1] |=> dac_code_o[19:10] == 10'h000)
      else $error("stopped dac code nonzero"); // RQ11
   // RQ7: status bit sticky
   chk_status_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.status[0] && !(bus_i.wr && bus_i.addr == INT_STATUS)) |=> q.status[0])
      else $error("status bit lost"); // RQ7
endmodule
`default_nettype wire

// [rtl/cmp_glitch_filter.sv]
/*
 per-comparator path: two-flop synchroniser, two-cycle glitch filter,
 one-cycle event pulse, asynchronous bypass for low power modes.
 assumes raw comparator level is asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_glitch_filter (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic raw_i,
   input  wire logic run_i,
   input  wire logic low_power_i,
   output logic      filt_o,
   output logic      pulse_o,
   output logic      wake_o
);
   import cmp_ctrl_pkg::*;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       cand;
      logic [1:0] cnt;
      logic       filt;
      logic       pulse;
   } filt_state_t;

   filt_state_t q, d;

   always_comb begin
      d = q;
      d.s1 = raw_i;
      d.s2 = q.s1;
      d.pulse = 1'b0;
      if (!run_i) begin
         d.cnt = 2'd0;
         d.filt = 1'b0;
         d.cand = 1'b0;
      end else if (q.s2 != q.filt) begin
         // RQ4: two stable cycles
         if (q.s2 != q.cand) begin
            d.cand = q.s2;
            d.cnt = 2'd1;
         end else if (q.cnt >= 2'(FILT_CYCLES - 1)) begin
            d.filt = q.s2;
            d.cnt = 2'd0;
            // RQ7: one-cycle event
            d.pulse = q.s2;
         end else begin
            d.cnt = q.cnt + 2'd1;
         end
      end else begin
         d.cand = q.filt;
         d.cnt = 2'd0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign filt_o = q.filt;
   assign pulse_o = q.pulse;
   // RQ5: filter bypassed for wake
   assign wake_o = low_power_i & run_i & raw_i;

   // RQ7: pulse lasts a single cycle
   chk_pulse_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      pulse_o |=> !pulse_o) else $error("event pulse wider than one cycle"); // RQ7
   sequence s_two_high;
      q.s2 && run_i ##1 q.s2 && run_i;
   endsequence
   // RQ4: short high ignored
   chk_glitch_masked: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(filt_o) |-> $past(q.s2, 1) && $past(q.s2, 2)) else $error("glitch passed"); // RQ4
   // RQ4: stable level passes
   chk_filter_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!filt_o && run_i) ##0 s_two_high ##1 (run_i && q.s2) |-> ##[0:1] filt_o)
      else $error("filter missed stable level"); // RQ4
endmodule
`default_nettype wire

// [rtl/cmp_reg_slot.sv]
/*
 register pair of one comparator: control and threshold code.
 assumes write strobes decoded by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_reg_slot (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       ctrl_we_i,
   input  wire logic                       code_we_i,
   input  wire logic [15:0]                wdata_i,
   output cmp_ctrl_pkg::ctrl_fields_t      fields_o,
   output logic [9:0]                      code_o
);
   import cmp_ctrl_pkg::*;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [9:0]  code;
   } slot_state_t;

   slot_state_t q, d;

   always_comb begin
      d = q;
      if (ctrl_we_i) begin
         d.ctrl = wdata_i & CTRL_WMASK;
      end
      if (code_we_i) begin
         d.code = 10'(wdata_i & CODE_WMASK);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         // RQ17: reset to zero
         q <= {CTRL_RESET, CODE_RESET};
      end else begin
         q <= d;
      end
   end

   assign fields_o = '{enable:   q.ctrl[EN_BIT],
                       stop_idle: q.ctrl[SIDL_BIT],
                       dac_oe:   q.ctrl[DAC_OUTPUT_ENABLE_BIT],
                       sel:      q.ctrl[SEL_LSB+:2],
                       ext_ref:  q.ctrl[EXT_BIT],
                       polarity: q.ctrl[POL_BIT],
                       range:    q.ctrl[RANGE_BIT]};
   assign code_o = q.code;

   // RQ14: reserved bits never stored
   chk_ctrl_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (q.ctrl & ~CTRL_WMASK) == 16'h0000) else $error("reserved control bit set"); // RQ14
endmodule
`default_nettype wire

// [verif/cmp_analog_model.sv]
/*
 behavioural model of the analog comparators and reference dacs.
 assumes the control block drives reference source and code outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model #(
   parameter int INTERNAL_REFERENCE_VOLTAGE_MV = 1200,
   parameter int HALF_MV   = 1650,
   parameter int EXTERNAL_REFERENCE_SELECT_MV = 1000
) (
   input  wire logic [cmp_ctrl_pkg::NUM_CMP*2-1:0]  ref_src_i,
   input  wire logic [cmp_ctrl_pkg::NUM_CMP*10-1:0] code_i,
   input  wire logic [cmp_ctrl_pkg::NUM_CMP*16-1:0] vin_mv_i,
   output logic [cmp_ctrl_pkg::NUM_CMP-1:0]         raw_o
);
   import cmp_ctrl_pkg::*;
   int ref_mv;
   always_comb begin
      ref_mv = 0;
      for (int i = 0; i < NUM_CMP; i++) begin
         case (ref_src_i[2*i +: 2])
            2'b00:   ref_mv = INTERNAL_REFERENCE_VOLTAGE_MV;
            2'b01:   ref_mv = HALF_MV;
            2'b10:   ref_mv = EXTERNAL_REFERENCE_SELECT_MV;
            default: ref_mv = 0;
         endcase
         // threshold is code times reference over 1024
         raw_o[i] = int'(vin_mv_i[16*i +: 16]) * 1024 > int'(code_i[10*i +: 10]) * ref_mv;
      end
   end
endmodule
`default_nettype wire

// [verif/cmp_bank_ctrl_tb.sv]
/*
 self-checking bench for the comparator bank control block.
 assumes the analog model drives the raw comparator levels.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_bank_ctrl_tb;
   import cmp_ctrl_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        rst_i      = 1'b1;
   bus_req_t    bus_q      = '0;
   logic        idle_q     = 1'b0;
   logic        sleep_q    = 1'b0;
   logic [63:0] vin_q      = '0;
   logic [15:0] rdata;
   logic [7:0]  in_sel;
   logic [15:0] ibuf_off;
   logic [3:0]  cmp_pwr;
   logic [7:0]  ref_src;
   logic [39:0] dac_code;
   logic [3:0]  dac_pin_en;
   logic [3:0]  cmp_out;
   logic [3:0]  adc_trig;
   logic [3:0]  irq_pulse;
   logic [3:0]  wake;
   logic        irq;
   logic [3:0]  raw;
   int          n_mismatch = 0;
   int          checks     = 0;
   int          nt;
   int          ni;

   always #25 core_clk_i = ~core_clk_i;

   cmp_bank_ctrl cmp_bank_ctrl_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus_q), .rdata_o(rdata),
      .cmp_raw_i(raw), .idle_i(idle_q), .sleep_i(sleep_q), .in_sel_o(in_sel),
      .pad_ibuf_off_o(ibuf_off), .cmp_power_o(cmp_pwr), .ref_src_o(ref_src),
      .dac_code_o(dac_code), .dac_pin_en_o(dac_pin_en), .cmp_out_o(cmp_out),
      .adc_trig_o(adc_trig), .irq_pulse_o(irq_pulse), .wake_o(wake), .irq_o(irq)
   );
   cmp_analog_model cmp_analog_model_inst (
      .ref_src_i(ref_src), .code_i(dac_code), .vin_mv_i(vin_q), .raw_o(raw)
   );

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      bus_q.wr <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      @(posedge core_clk_i);
      bus_q <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      bus_q.rd <= 1'b0;
      #1;
      d = rdata;
      chk({24'h0, d}, {24'h0, exp});
   endtask
   // which: 0 filtered output, 1 wake, 2 interrupt
   task automatic wait_for(input int which, input int i, input logic val);
      int   n;
      logic v;
      n = 0;
      v = ~val;
      while (v !== val) begin
         @(posedge core_clk_i);
         #1;
         v = (which == 0) ? cmp_out[i] : (which == 1) ? wake[i] : irq;
         n++;
         if (n > 40) begin
            n_mismatch++;
            $display("unexpected at %0t: wait ran out, seen %0h expected %0h", $time, v, val);
            complete_run();
         end
      end
   endtask
   task automatic watch(input int cyc);
      nt = 0;
      ni = 0;
      repeat (cyc) begin
         @(posedge core_clk_i);
         #1;
         nt += int'(adc_trig[0] === 1'b1);
         ni += int'(irq_pulse[0] === 1'b1);
      end
   endtask

   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      chk(ref_src, 8'hFF);
      chk(cmp_pwr, 4'h0);
      chk(dac_code, 40'h0);
      rdchk(4'h0, 16'h0000);
      rdchk(4'h1, 16'h0000);
      $display("test reset done");
      bus_wr(4'h0, 16'hFFFD);
      rdchk(4'h0, 16'hA1E1);
      chk(ref_src[1:0], 2'b10);
      chk(dac_pin_en, 4'h1);
      chk(cmp_pwr, 4'h1);
      bus_wr(4'h1, 16'hFFFF);
      rdchk(4'h1, 16'h03FF);
      chk(dac_code[9:0], 10'h3FF);
      rdchk(4'hA, 16'h0000);
      bus_wr(4'h0, 16'h0000);
      chk(cmp_pwr[0], 1'b0);
      bus_wr(4'h4, 16'h8100);
      chk(dac_pin_en, 4'h4);
      for (int s = 0; s < 4; s++) begin
         bus_wr(4'h0, {8'h80, s[1:0], 6'h00});
         chk(in_sel[1:0], s[1:0]);
         chk(ibuf_off[3:0], 4'h1 << s);
      end
      chk(ref_src[1:0], 2'b00);
      bus_wr(4'h0, 16'h8001);
      chk(ref_src[1:0], 2'b01);
      $display("test registers done");
      bus_wr(4'h1, 16'h0200);
      @(posedge core_clk_i);
      vin_q[15:0] <= 16'd1000;
      @(posedge core_clk_i);
      vin_q[15:0] <= 16'd0;
      watch(12);
      chk(nt, 0);
      chk(cmp_out[0], 1'b0);
      @(posedge core_clk_i);
      vin_q[15:0] <= 16'd1000;
      watch(20);
      chk(nt, 1);
      chk(ni, 1);
      chk(cmp_out[0], 1'b1);
      rdchk(4'h0, 16'h8009);
      rdchk(4'h8, 16'h0001);
      bus_wr(4'h9, 16'h0001);
      chk(irq, 1'b1);
      bus_wr(4'h8, 16'h0001);
      chk(irq, 1'b0);
      $display("test filter done");
      bus_wr(4'h0, 16'h8003);
      wait_for(0, 0, 1'b0);
      chk(cmp_out[0], 1'b0);
      rdchk(4'h0, 16'h8003);
      @(posedge core_clk_i);
      vin_q[15:0] <= 16'd0;
      wait_for(0, 0, 1'b1);
      chk(cmp_out[0], 1'b1);
      bus_wr(4'h8, 16'h0001);
      $display("test polarity done");
      bus_wr(4'h0, 16'hA001);
      bus_wr(4'h3, 16'h0200);
      bus_wr(4'h2, 16'h8001);
      @(posedge core_clk_i);
      vin_q[31:16] <= 16'd1000;
      wait_for(0, 1, 1'b1);
      @(posedge core_clk_i);
      idle_q <= 1'b1;
      wait_for(0, 1, 1'b0);
      chk(cmp_out[1], 1'b0);
      @(posedge core_clk_i);
      idle_q <= 1'b0;
      wait_for(0, 1, 1'b1);
      chk(cmp_out[1], 1'b1);
      chk(wake, 4'h0);
      @(posedge core_clk_i);
      sleep_q <= 1'b1;
      wait_for(1, 1, 1'b1);
      chk(wake[1], 1'b1);
      @(posedge core_clk_i);
      vin_q[31:16] <= 16'd0;
      #1;
      chk(wake[1], 1'b0);
      @(posedge core_clk_i);
      sleep_q <= 1'b0;
      vin_q[31:16] <= 16'd1000;
      bus_wr(4'h2, 16'h0001);
      wait_for(0, 1, 1'b0);
      chk(cmp_pwr[1], 1'b0);
      $display("test low power done");
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      chk(ref_src, 8'hFF);
      rdchk(4'h2, 16'h0000);
      rdchk(4'h8, 16'h0000);
      $display("test mid reset done");
      complete_run();
   end
endmodule
`default_nettype wire
